// ===== rtl/ipc_consts.svh
`ifndef IPC_CONSTS_SVH
`define IPC_CONSTS_SVH

`define IPC_OFS_PRIO_A 8'h00
`define IPC_OFS_PRIO_B 8'h04
`define IPC_OFS_EVENT 8'h08
`define IPC_OFS_STATUS 8'h0c
`define IPC_PRIO_RESET 16'h0000
`define IPC_EVENT_RESET 12'h000
`define IPC_RESV_MASK 16'hfff0
`define IPC_RESP_OKAY 2'b00
`define IPC_RESP_SLVERR 2'b10

`define IPC_LVL_NONE 5'h00
`define IPC_LVL_NMI 5'h10
`define IPC_IRL_NONE 4'hf
`define IPC_CODE_NMI 12'h1c0
`define IPC_CODE_IRL_BASE 12'h200
`define IPC_CODE_TMR0_UNF 12'h400
`define IPC_CODE_TMR1_UNF 12'h420
`define IPC_CODE_TMR2_UNF 12'h440
`define IPC_CODE_TMR2_CAP 12'h460
`define IPC_CODE_ALARM 12'h480
`define IPC_CODE_PERIODIC 12'h4a0
`define IPC_CODE_CARRY 12'h4c0
`define IPC_CODE_RX_ERR 12'h4e0
`define IPC_CODE_RX_FULL 12'h500
`define IPC_CODE_TX_EMPTY 12'h520
`define IPC_CODE_TX_END 12'h540
`define IPC_CODE_INTERVAL 12'h560
`define IPC_CODE_REF_MATCH 12'h580
`define IPC_CODE_REF_OVF 12'h5a0

`define IPC_FLD_HI 15:12
`define IPC_FLD_MH 11:8
`define IPC_FLD_ML 7:4
`define IPC_FLD_LO 3:0
`define IPC_NUM_SRC 16

`endif

// ===== rtl/ipc_pkg.sv
package ipc_pkg;

   typedef struct packed {
      logic timer0_underflow;
      logic timer1_underflow;
      logic timer2_underflow;
      logic timer2_capture;
      logic alarm_irq;
      logic periodic_irq;
      logic carry_irq;
      logic rx_error_irq;
      logic rx_full_irq;
      logic tx_empty_irq;
      logic tx_end_irq;
      logic interval_irq;
      logic refresh_match_irq;
      logic refresh_overflow_irq;
   } ipc_mod_src_s;

   typedef struct packed {
      logic [4:0] level;
      logic [11:0] code;
   } ipc_winner_s;

endpackage

// ===== rtl/ipc_top.sv
`timescale 1ns/1ps
`include "ipc_consts.svh"

module ipc_top
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic nmi_req,
   input wire logic [3:0] encoded_level_inputs,
   input wire ipc_pkg::ipc_mod_src_s mod_src,
   input wire logic [3:0] cpu_mask_level,
   input wire logic cpu_accept,
   output logic cpu_irq,
   output ipc_pkg::ipc_winner_s winner,
   output logic [11:0] event_code_register
);

   ////////////////////////////////////////////////////////////////////
   // register and bus state

   logic [15:0] prio_a_r, prio_a_nxt;
   logic [15:0] prio_b_r, prio_b_nxt;
   logic [11:0] event_r, event_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic aw_held_r, aw_held_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic w_held_r, w_held_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   ipc_pkg::ipc_winner_s win_r, win_nxt;
   logic irq_r, irq_nxt;

   logic do_wr;
   logic [7:0] wr_ofs;
   logic [7:0] rd_ofs;
   logic [15:0] wr_merge_a;
   logic [15:0] wr_merge_b;

   logic [4:0] src_lvl [`IPC_NUM_SRC];
   logic [11:0] src_code [`IPC_NUM_SRC];

   ////////////////////////////////////////////////////////////////////
   // source table, listed in default rank order

   always_comb
   begin
      src_lvl[0] = nmi_req ? `IPC_LVL_NMI : `IPC_LVL_NONE;
      src_code[0] = `IPC_CODE_NMI;
      // all ones is idle; otherwise level is the inverted pattern
      src_lvl[1] = (encoded_level_inputs == `IPC_IRL_NONE) ?
         `IPC_LVL_NONE : {1'b0, ~encoded_level_inputs};
      src_code[1] = `IPC_CODE_IRL_BASE +
         {3'h0, encoded_level_inputs, 5'h00};
      src_lvl[2] = mod_src.timer0_underflow ?
         {1'b0, prio_a_r[`IPC_FLD_HI]} : `IPC_LVL_NONE;
      src_code[2] = `IPC_CODE_TMR0_UNF;
      src_lvl[3] = mod_src.timer1_underflow ?
         {1'b0, prio_a_r[`IPC_FLD_MH]} : `IPC_LVL_NONE;
      src_code[3] = `IPC_CODE_TMR1_UNF;
      src_lvl[4] = mod_src.timer2_underflow ?
         {1'b0, prio_a_r[`IPC_FLD_ML]} : `IPC_LVL_NONE;
      src_code[4] = `IPC_CODE_TMR2_UNF;
      src_lvl[5] = mod_src.timer2_capture ?
         {1'b0, prio_a_r[`IPC_FLD_ML]} : `IPC_LVL_NONE;
      src_code[5] = `IPC_CODE_TMR2_CAP;
      src_lvl[6] = mod_src.alarm_irq ?
         {1'b0, prio_a_r[`IPC_FLD_LO]} : `IPC_LVL_NONE;
      src_code[6] = `IPC_CODE_ALARM;
      src_lvl[7] = mod_src.periodic_irq ?
         {1'b0, prio_a_r[`IPC_FLD_LO]} : `IPC_LVL_NONE;
      src_code[7] = `IPC_CODE_PERIODIC;
      src_lvl[8] = mod_src.carry_irq ?
         {1'b0, prio_a_r[`IPC_FLD_LO]} : `IPC_LVL_NONE;
      src_code[8] = `IPC_CODE_CARRY;
      src_lvl[9] = mod_src.rx_error_irq ?
         {1'b0, prio_b_r[`IPC_FLD_ML]} : `IPC_LVL_NONE;
      src_code[9] = `IPC_CODE_RX_ERR;
      src_lvl[10] = mod_src.rx_full_irq ?
         {1'b0, prio_b_r[`IPC_FLD_ML]} : `IPC_LVL_NONE;
      src_code[10] = `IPC_CODE_RX_FULL;
      src_lvl[11] = mod_src.tx_empty_irq ?
         {1'b0, prio_b_r[`IPC_FLD_ML]} : `IPC_LVL_NONE;
      src_code[11] = `IPC_CODE_TX_EMPTY;
      src_lvl[12] = mod_src.tx_end_irq ?
         {1'b0, prio_b_r[`IPC_FLD_ML]} : `IPC_LVL_NONE;
      src_code[12] = `IPC_CODE_TX_END;
      src_lvl[13] = mod_src.interval_irq ?
         {1'b0, prio_b_r[`IPC_FLD_HI]} : `IPC_LVL_NONE;
      src_code[13] = `IPC_CODE_INTERVAL;
      src_lvl[14] = mod_src.refresh_match_irq ?
         {1'b0, prio_b_r[`IPC_FLD_MH]} : `IPC_LVL_NONE;
      src_code[14] = `IPC_CODE_REF_MATCH;
      src_lvl[15] = mod_src.refresh_overflow_irq ?
         {1'b0, prio_b_r[`IPC_FLD_MH]} : `IPC_LVL_NONE;
      src_code[15] = `IPC_CODE_REF_OVF;
   end

   ////////////////////////////////////////////////////////////////////
   // resolver: strict compare so the earlier rank keeps a tie

   always_comb
   begin
      win_nxt.level = `IPC_LVL_NONE;
      win_nxt.code = `IPC_EVENT_RESET;
      for (int i = 0; i < `IPC_NUM_SRC; i++)
      begin
         if (src_lvl[i] > win_nxt.level)
         begin
            win_nxt.level = src_lvl[i];
            win_nxt.code = src_code[i];
         end
      end
      // a zero-level winner can never beat a 4-bit mask
      irq_nxt = (win_nxt.level > {1'b0, cpu_mask_level});
      // the core fetches from one common entry and uses this as offset
      event_nxt = (cpu_accept && irq_r) ? win_r.code : event_r;
   end

   ////////////////////////////////////////////////////////////////////
   // bus slave: write address and data are latched independently

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign do_wr = aw_held_r && w_held_r;
   assign wr_ofs = {awaddr_r[7:2], 2'b00};
   assign rd_ofs = {s_axi_araddr[7:2], 2'b00};

   always_comb
   begin
      wr_merge_a = prio_a_r;
      wr_merge_b = prio_b_r;
      if (wstrb_r[0])
      begin
         wr_merge_a[7:0] = wdata_r[7:0];
         wr_merge_b[7:0] = wdata_r[7:0];
      end
      if (wstrb_r[1])
      begin
         wr_merge_a[15:8] = wdata_r[15:8];
         wr_merge_b[15:8] = wdata_r[15:8];
      end
   end

   always_comb
   begin
      awaddr_nxt = awaddr_r;
      aw_held_nxt = aw_held_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      w_held_nxt = w_held_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      prio_a_nxt = prio_a_r;
      prio_b_nxt = prio_b_r;
      if (s_axi_awvalid && s_axi_awready)
      begin
         awaddr_nxt = s_axi_awaddr;
         aw_held_nxt = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
         w_held_nxt = 1'b1;
      end
      if (do_wr)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = `IPC_RESP_OKAY;
         unique case (wr_ofs)
            `IPC_OFS_PRIO_A: prio_a_nxt = wr_merge_a;
            // reserved nibble is forced to zero so it reads back zero
            `IPC_OFS_PRIO_B:
               prio_b_nxt = wr_merge_b & `IPC_RESV_MASK;
            `IPC_OFS_EVENT, `IPC_OFS_STATUS: ;
            default: bresp_nxt = `IPC_RESP_SLVERR;
         endcase
      end
      if (bvalid_r && s_axi_bready)
         bvalid_nxt = 1'b0;
   end

   always_comb
   begin
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `IPC_RESP_OKAY;
         unique case (rd_ofs)
            `IPC_OFS_PRIO_A: rdata_nxt = {16'h0000, prio_a_r};
            `IPC_OFS_PRIO_B: rdata_nxt = {16'h0000, prio_b_r};
            `IPC_OFS_EVENT: rdata_nxt = {20'h00000, event_r};
            `IPC_OFS_STATUS:
               rdata_nxt = {14'h0000, irq_r, win_r.level, win_r.code};
            default:
            begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = `IPC_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_r && s_axi_rready)
         rvalid_nxt = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // registers, one process per group of state

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         win_r <= '0;
         irq_r <= 1'b0;
         event_r <= `IPC_EVENT_RESET;
      end
      else
      begin
         win_r <= win_nxt;
         irq_r <= irq_nxt;
         event_r <= event_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prio_a_r <= `IPC_PRIO_RESET;
         prio_b_r <= `IPC_PRIO_RESET;
         awaddr_r <= 8'h00;
         aw_held_r <= 1'b0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         w_held_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `IPC_RESP_OKAY;
      end
      else
      begin
         prio_a_r <= prio_a_nxt;
         prio_b_r <= prio_b_nxt;
         awaddr_r <= awaddr_nxt;
         aw_held_r <= aw_held_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         w_held_r <= w_held_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rvalid_r <= 1'b0;
         rresp_r <= `IPC_RESP_OKAY;
         rdata_r <= 32'h00000000;
      end
      else
      begin
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // registered outputs; one cycle of latency keeps the resolver
   // off the core's timing path
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign winner = win_r;
   assign cpu_irq = irq_r;
   assign event_code_register = event_r;

endmodule

// ===== verification/interrupt_priority_event_coder_tb.sv
`timescale 1ns/1ps
`include "ipc_consts.svh"
module interrupt_priority_event_coder_tb;
   logic sys_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, nmi_req, cpu_accept, cpu_irq;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, block_bit;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb, encoded_level_inputs, cpu_mask_level, dly;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [11:0] event_code_register;
   ipc_pkg::ipc_mod_src_s mod_src;
   ipc_pkg::ipc_winner_s winner;
   logic [4:0] lv [14] = '{5'h09, 5'h08, 5'h07, 5'h07, 5'h06, 5'h06, 5'h06,
      5'h03, 5'h03, 5'h03, 5'h03, 5'h05, 5'h04, 5'h04};
   int err_total = 0;
   int n_compared = 0;
   ipc_top i_dut (.*);
   ipc_core_model i_core (.sys_clk, .rstn, .cpu_irq, .accept_delay(dly),
      .block_bit, .cpu_accept);
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkw(input logic [4:0] l, input logic [11:0] c);
      chk("winner level", {27'h0, l}, {27'h0, winner.level});
      chk("winner code", {20'h0, c}, {20'h0, winner.code});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge sys_clk);
         if (!aw && s_axi_awready)
         begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready)
         begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge sys_clk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic src(input logic n, input logic [3:0] e, m4, input
      logic [13:0] m);
      @(posedge sys_clk);
      nmi_req <= n;
      encoded_level_inputs <= e;
      cpu_mask_level <= m4;
      mod_src <= m;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic prio_set(input logic [15:0] a, b);
      @(posedge sys_clk);
      block_bit <= 1'b1;
      wr(`IPC_OFS_PRIO_A, {16'h0, a});
      wr(`IPC_OFS_PRIO_B, {16'h0, b});
      rdr(`IPC_OFS_PRIO_A);
      chk("prio_a", {16'h0, a}, rd);
      rdr(`IPC_OFS_PRIO_B);
      chk("prio_b", {16'h0, b}, rd);
      block_bit <= 1'b0;
   endtask
   task automatic t_regs;
      rdr(`IPC_OFS_PRIO_A);
      chk("prio_a", 32'h0, rd);
      chk("rresp", 32'h0, {30'h0, rsp});
      rdr(`IPC_OFS_PRIO_B);
      chk("prio_b", 32'h0, rd);
      wr(`IPC_OFS_PRIO_B, 32'hffff_123f);
      chk("bresp", 32'h0, {30'h0, rsp});
      rdr(`IPC_OFS_PRIO_B);
      chk("prio_b", 32'h1230, rd);
      @(posedge sys_clk);
      s_axi_wstrb <= 4'h2;
      wr(`IPC_OFS_PRIO_B, 32'hffff_ffff);
      s_axi_wstrb <= 4'hf;
      rdr(`IPC_OFS_PRIO_B);
      chk("prio_b strobe", 32'hff30, rd);
      wr(8'h10, 32'h0000_0001);
      chk("unmapped bresp", 32'h2, {30'h0, rsp});
      rdr(8'h10);
      chk("unmapped resp", 32'h2, {30'h0, rsp});
      $display("regs test done");
   endtask
   task automatic t_field;
      prio_set(16'h9876, 16'h5430);
      for (int i = 0; i < 14; i++)
      begin
         src(1'b0, 4'hf, 4'h0, 14'h2000 >> i);
         chkw(lv[i], 12'h400 + 12'h20 * 12'(i));
      end
      $display("field test done");
   endtask
   task automatic t_rank;
      prio_set(16'h7777, 16'h7770);
      for (int i = 0; i < 14; i++)
      begin
         src(1'b0, 4'hf, 4'h0, 14'h3fff >> i);
         chkw(5'h07, 12'h400 + 12'h20 * 12'(i));
      end
      src(1'b0, 4'h8, 4'h0, 14'h3fff);
      chkw(5'h07, 12'h300);
      src(1'b1, 4'h0, 4'h0, 14'h3fff);
      chkw(5'h10, 12'h1c0);
      $display("rank test done");
   endtask
   task automatic t_irl;
      for (int p = 0; p < 16; p++)
      begin
         src(1'b0, 4'(p), 4'h0, 14'h0);
         if (p == 15)
            chkw(5'h00, 12'h000);
         else
            chkw(5'h0f - 5'(p), 12'h200 + 12'h20 * 12'(p));
      end
      $display("encoded test done");
   endtask
   task automatic t_accept;
      @(posedge sys_clk);
      dly <= 4'h5;
      prio_set(16'h0000, 16'h0000);
      src(1'b0, 4'hf, 4'h0, 14'h3fff);
      chkw(5'h00, 12'h000);
      prio_set(16'h3000, 16'h9000);
      src(1'b0, 4'hf, 4'h3, 14'h2004);
      chkw(5'h09, 12'h560);
      repeat (10) @(posedge sys_clk);
      chk("event code", 32'h560, {20'h0, event_code_register});
      src(1'b0, 4'hf, 4'h9, 14'h2004);
      chk("irq", 32'h0, {31'h0, cpu_irq});
      src(1'b0, 4'hf, 4'h8, 14'h2004);
      chk("irq", 32'h1, {31'h0, cpu_irq});
      rdr(`IPC_OFS_STATUS);
      chk("status", 32'h0002_9560, rd);
      wr(`IPC_OFS_EVENT, 32'h0);
      rdr(`IPC_OFS_EVENT);
      chk("event read", 32'h560, rd);
      $display("accept test done");
   endtask
   task automatic t_reset;
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      rdr(`IPC_OFS_PRIO_A);
      chk("prio_a", 32'h0, rd);
      rdr(`IPC_OFS_PRIO_B);
      chk("prio_b", 32'h0, rd);
      chk("irq", 32'h0, {31'h0, cpu_irq});
      $display("reset test done");
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, nmi_req} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      encoded_level_inputs = 4'hf;
      {cpu_mask_level, dly} = 8'h0;
      mod_src = '0;
      block_bit = 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      t_regs;
      t_field;
      t_rank;
      t_irl;
      t_accept;
      t_reset;
      tally_and_finish;
   end
   initial
   begin
      repeat (4000) @(posedge sys_clk);
      err_total++;
      tally_and_finish;
   end
endmodule

// ===== verification/ipc_core_model.sv
`timescale 1ns/1ps
module ipc_core_model
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic cpu_irq,
   input wire logic [3:0] accept_delay,
   input wire logic block_bit,
   output logic cpu_accept
);
   logic [3:0] wait_r, wait_nxt;
   logic acc_nxt;
   // core takes the request after a settable pause at an instruction break;
   // while the block bit is set it takes nothing and the pause restarts
   always_comb
   begin
      wait_nxt = (cpu_irq && !cpu_accept && !block_bit) ? wait_r + 4'h1 :
         4'h0;
      acc_nxt = cpu_irq && !cpu_accept && !block_bit &&
         wait_r == accept_delay;
   end
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wait_r <= 4'h0;
         cpu_accept <= 1'b0;
      end
      else
      begin
         wait_r <= wait_nxt;
         cpu_accept <= acc_nxt;
      end
   end
endmodule

// ===== verification/ipc_props.sv
`timescale 1ns/1ps
module ipc_props
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic nmi_req,
   input wire logic [3:0] encoded_level_inputs,
   input wire ipc_pkg::ipc_mod_src_s mod_src,
   input wire logic [3:0] cpu_mask_level,
   input wire logic cpu_accept,
   input wire logic cpu_irq,
   input wire ipc_pkg::ipc_winner_s winner,
   input wire logic [11:0] event_code_register
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_nmi_top:
      assert property (nmi_req |=> winner == {5'h10, 12'h1c0})
         else $error("nmi not on top");
   a_idle_empty:
      assert property (!nmi_req && encoded_level_inputs == 4'hf
         && mod_src == '0 |=> winner == '0) else $error("idle winner");
   a_irl_map:
      assert property (!nmi_req && encoded_level_inputs != 4'hf
         && mod_src == '0 |=> winner.level == 5'h0f
         - {1'b0, $past(encoded_level_inputs)} && winner.code == 12'h200
         + {3'h0, $past(encoded_level_inputs), 5'h00})
         else $error("encoded level map");
   // stable operands make the check hold because irq is registered once
   // behind the sources, in the same cycle as the winner
   a_irq_compare:
      assert property ($stable(winner) && $stable(cpu_mask_level) |->
         cpu_irq == (winner.level > {1'b0, cpu_mask_level}))
         else $error("irq compare");
   a_event_load:
      assert property (cpu_accept && cpu_irq |=>
         event_code_register == $past(winner.code)) else $error("event load");
   a_event_hold:
      assert property (!(cpu_accept && cpu_irq) |=>
         $stable(event_code_register)) else $error("event moved");
   a_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
         && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
         && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_bvalid_drop:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
         else $error("bvalid stuck");
   a_rvalid_drop:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
         else $error("rvalid stuck");
endmodule
////////////////////////////////////////
bind ipc_top ipc_props i_props (.*);
